// [verilog/ulpm_regs.svh]
// Register offsets, field positions, reset values and timing counts of the LPM block
`ifndef ULPM_REGS_SVH
`define ULPM_REGS_SVH
`define ULPM_CFG_OFFSET 12'h054
`define ULPM_STAT_OFFSET 12'h058
`define ULPM_CFG_RESET 32'h0000_0000
`define ULPM_B_ATTACH 30
`define ULPM_B_INVSEL 31
`define ULPM_F_RETLEFT_LSB 25
`define ULPM_B_SEND 24
`define ULPM_F_RETLIM_LSB 21
`define ULPM_F_CHAN_LSB 17
`define ULPM_B_RESOK 16
`define ULPM_B_SLEEP 15
`define ULPM_F_RESP_LSB 13
`define ULPM_F_THRES_LSB 8
`define ULPM_B_PHYSLP 7
`define ULPM_B_RWAKE 6
`define ULPM_F_RESUME_DURATION_CODE_LSB 2
`define ULPM_B_SWRESP 1
`define ULPM_B_CAP 0
`define ULPM_CLK_MHZ 10
`define ULPM_RESIDENCY_US 50
`define ULPM_RESIDENCY_CYC (`ULPM_RESIDENCY_US * `ULPM_CLK_MHZ)
`define ULPM_RESUME_DURATION_CODE_BASE_US 50
`define ULPM_RESUME_DURATION_CODE_STEP_US 75
`define ULPM_THRES_BASE_US 60
`endif

// [verilog/ulpm_pkg.sv]
// Types shared by the LPM control block
package ulpm_pkg;
	typedef enum logic [1:0] {
		ULPM_RESP_ERROR = 2'h0,
		ULPM_RESP_STALL = 2'h1,
		ULPM_RESP_NYET = 2'h2,
		ULPM_RESP_ACK = 2'h3
	} ulpm_resp_e;
	typedef enum logic [3:0] {
		ULPM_H_IDLE = 4'h1,
		ULPM_H_SEND = 4'h2,
		ULPM_H_WAIT = 4'h4,
		ULPM_H_DONE = 4'h8
	} ulpm_host_e;
	typedef enum logic [2:0] {
		ULPM_A_IDLE = 3'h1,
		ULPM_A_WAIT_IDLE = 3'h2,
		ULPM_A_CONNECT = 3'h4
	} ulpm_attach_e;
endpackage : ulpm_pkg

// [verilog/ulpm_control.sv]
// LPM control and status logic with AHB-Lite register access
// Behaviour
// RULE1: Attach set: host drives idle and waits; device waits idle then connects.
// RULE2: Attach bit writable only with strobe option, select high, invert clear.
// RULE3: Read-only field shows host LPM retries still to send.
// RULE4: Host send bit emits EXT then LPM; cleared on handshake or retries exhausted.
// RULE5: Software sets send bit only while host attached to local port.
// RULE6: After ERROR the host retries up to retry limit, stopping on handshake.
// RULE7: Device address and endpoint come from the selected host channel.
// RULE8: Resume-permitted sets after 50 us in L1, clears when sleep flag clear.
// RULE9: Device sleep sets after sent ACK and token-retry timer; clears on activity.
// RULE10: Device software confirms sleep by sleep flag and stops PHY clock.
// RULE11: Host sleep sets on ACKed LPM; clears on wakeup, reset, resume, irq bits.
// RULE12: Response field: 11 ACK, 10 NYET, 01 STALL, 00 ERROR.
// RULE13: Deep low-power out in device L1 when threshold enabled and code reaches it.
// RULE14: Threshold low bits encode resume time, 60 us plus 75 us per step.
// RULE15: ULPI with PHY-sleep enable writes PHY function control bit 7 in L1.
// RULE16: Non-ULPI passes sleep to PHY in L1 when enabled and no deep suspend.
// RULE17: Software keeps PHY-sleep enable set with ULPI, even during resume.
// RULE18: Host sends remote-wake bit; device captures it on ACK, NYET or STALL.
// RULE19: Host sends and times resume code; device captures code on handshake.
// RULE20: LPM-capable clear makes device answer every LPM token with NYET.
// RULE21: ACK programmed: ERROR on token errors, STALL unless L1, NYET if pending.
// RULE22: NYET programmed: still STALL when not L1, ERROR on corrupted tokens.
// RULE23: LPM-capable bit writable only with LPM option; otherwise reads zero.
// RULE24: Without LPM-capable, no LPM requests as host, no LPM responses as device; the code still answers device tokens with NYET.
// RULE25: Reserved configuration bits read zero and ignore writes.
//
// Decided for this implementation: the register addresses and register access over AHB-Lite.
`include "ulpm_regs.svh"
module ulpm_control #(
	parameter bit LPM_BUILD_OPTION = 1'b1,
	parameter bit STROBE_LINK_OPTION = 1'b1,
	parameter bit ULPI_PHY = 1'b0,
	parameter int RESUME_CYC_MAX = 12000
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic host_mode,
	input wire logic strobe_link_select,
	input wire logic line_idle,
	input wire logic bus_activity,
	input wire logic [6:0] chan_dev_addr,
	input wire logic [3:0] chan_ep_num,
	input wire logic lpm_tx_ready,
	input wire logic lpm_rx_valid,
	input wire logic [1:0] lpm_rx_code,
	input wire logic dev_tok_valid,
	input wire logic dev_tok_error,
	input wire logic [3:0] dev_tok_link_state,
	input wire logic dev_tok_rwake,
	input wire logic [3:0] dev_tok_resume_duration_code,
	input wire logic dev_tx_pending,
	input wire logic token_retry_timer,
	input wire logic remote_wakeup_signal,
	input wire logic port_reset,
	input wire logic soft_disconnect,
	input wire logic remote_l1_wakeup,
	input wire logic host_l1_resume,
	input wire logic l1_wakeup_irq,
	input wire logic disconnect_irq,
	output logic [3:0] lpm_channel_index_out,
	output logic lpm_tx_start,
	output logic [6:0] lpm_tx_dev_addr,
	output logic [3:0] lpm_tx_ep_num,
	output logic lpm_tx_rwake,
	output logic [3:0] lpm_tx_resume_duration_code,
	output logic dev_resp_valid,
	output logic [1:0] dev_resp_code,
	output logic host_drive_idle,
	output logic dev_connect_start,
	output logic host_resume_drive,
	output logic deep_low_power_out,
	output logic phy_l1_suspend_n_out,
	output logic phy_sleep_n_out,
	output logic ulpi_func_ctrl_wr,
	output logic ulpi_func_ctrl_bit7
);
	import ulpm_pkg::*;

	localparam int RES_CYC = `ULPM_RESIDENCY_CYC;

	// Synchronised pins
	logic idle_s1, idle_s2, act_s1, act_s2;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_s1 <= 1'b0;
			idle_s2 <= 1'b0;
			act_s1 <= 1'b0;
			act_s2 <= 1'b0;
		end else begin
			idle_s1 <= line_idle;
			idle_s2 <= idle_s1;
			act_s1 <= bus_activity;
			act_s2 <= act_s1;
		end
	end

	// Configuration fields
	logic invsel_reg, attach_reg, send_reg, resok_reg, sleep_reg, physlp_reg, rwake_reg;
	logic swresp_reg, cap_reg;
	logic [2:0] retleft_reg, retlim_reg;
	logic [3:0] chan_reg, resume_duration_code_reg;
	logic [1:0] resp_reg;
	logic [4:0] thres_reg;
	logic [31:0] cfg_rd;
	ulpm_host_e h_state;
	logic [3:0] host_fsm_code;
	logic host_acked;
	assign cfg_rd = {invsel_reg, attach_reg, 2'h0, retleft_reg, send_reg, retlim_reg,
		chan_reg, resok_reg, sleep_reg, resp_reg, thres_reg, physlp_reg, rwake_reg,
		resume_duration_code_reg, swresp_reg, cap_reg}; // [RULE25]

	// AHB-Lite slave: zero wait states, always OKAY
	logic ph_wr, ph_rd;
	logic [11:0] ph_addr;
	logic wr_cfg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr <= 1'b0;
			ph_rd <= 1'b0;
			ph_addr <= 12'h000;
		end else if (hready) begin
			ph_wr <= hsel && htrans[1] && hwrite;
			ph_rd <= hsel && htrans[1] && !hwrite;
			ph_addr <= haddr;
		end
	end
	assign wr_cfg = ph_wr && (ph_addr == `ULPM_CFG_OFFSET);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready && hsel && htrans[1] && !hwrite) begin
				if (haddr == `ULPM_CFG_OFFSET)
					hrdata <= cfg_rd;
				else if (haddr == `ULPM_STAT_OFFSET)
					hrdata <= {28'h0000000, host_fsm_code};
				else
					hrdata <= 32'h0000_0000;
			end
		end
	end

	// Software-owned fields
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			invsel_reg <= 1'b0;
			chan_reg <= 4'h0;
			thres_reg <= 5'h00;
			physlp_reg <= 1'b0;
			swresp_reg <= 1'b0;
			cap_reg <= 1'b0;
			retlim_reg <= 3'h0;
		end else if (wr_cfg) begin
			if (STROBE_LINK_OPTION)
				invsel_reg <= hwdata[`ULPM_B_INVSEL];
			chan_reg <= hwdata[`ULPM_F_CHAN_LSB +: 4];
			thres_reg <= hwdata[`ULPM_F_THRES_LSB +: 5]; // [RULE14]
			physlp_reg <= hwdata[`ULPM_B_PHYSLP];
			swresp_reg <= hwdata[`ULPM_B_SWRESP];
			retlim_reg <= hwdata[`ULPM_F_RETLIM_LSB +: 3];
			if (LPM_BUILD_OPTION)
				cap_reg <= hwdata[`ULPM_B_CAP]; // [RULE23]
		end
	end

	// Strobe-link attach
	logic attach_wr_ok;
	ulpm_attach_e att_state;
	assign attach_wr_ok = STROBE_LINK_OPTION && strobe_link_select && !invsel_reg;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			attach_reg <= 1'b0;
		else if (wr_cfg && attach_wr_ok)
			attach_reg <= hwdata[`ULPM_B_ATTACH]; // [RULE2]
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			att_state <= ULPM_A_IDLE;
			host_drive_idle <= 1'b0;
			dev_connect_start <= 1'b0;
		end else begin
			dev_connect_start <= 1'b0;
			host_drive_idle <= attach_reg && host_mode; // [RULE1]
			case (att_state)
				ULPM_A_IDLE: begin
					if (attach_reg && !host_mode)
						att_state <= ULPM_A_WAIT_IDLE;
				end
				ULPM_A_WAIT_IDLE: begin
					if (!attach_reg || host_mode)
						att_state <= ULPM_A_IDLE;
					else if (idle_s2) begin
						att_state <= ULPM_A_CONNECT;
						dev_connect_start <= 1'b1; // [RULE1]
					end
				end
				ULPM_A_CONNECT: begin
					if (!attach_reg || host_mode)
						att_state <= ULPM_A_IDLE;
				end
				default: att_state <= ULPM_A_IDLE;
			endcase
		end
	end

	// Host LPM transaction sequencer
	assign host_fsm_code = h_state;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			h_state <= ULPM_H_IDLE;
			send_reg <= 1'b0;
			retleft_reg <= 3'h0;
			lpm_tx_start <= 1'b0;
			host_acked <= 1'b0;
		end else begin
			lpm_tx_start <= 1'b0;
			host_acked <= 1'b0;
			case (h_state)
				ULPM_H_IDLE: begin
					if (wr_cfg && hwdata[`ULPM_B_SEND] && host_mode && cap_reg) begin // [RULE24]
						send_reg <= 1'b1;
						retleft_reg <= retlim_reg; // [RULE6]
						h_state <= ULPM_H_SEND;
					end
				end
				ULPM_H_SEND: begin
					if (lpm_tx_ready) begin
						lpm_tx_start <= 1'b1; // [RULE4]
						h_state <= ULPM_H_WAIT;
					end
				end
				ULPM_H_WAIT: begin
					if (lpm_rx_valid) begin
						if (lpm_rx_code != ULPM_RESP_ERROR) begin
							send_reg <= 1'b0; // [RULE4]
							host_acked <= (lpm_rx_code == ULPM_RESP_ACK);
							h_state <= ULPM_H_DONE;
						end else if (retleft_reg != 3'h0) begin
							retleft_reg <= retleft_reg - 3'h1; // [RULE3] [RULE6]
							h_state <= ULPM_H_SEND;
						end else begin
							send_reg <= 1'b0; // [RULE4]
							h_state <= ULPM_H_DONE;
						end
					end
				end
				ULPM_H_DONE: h_state <= ULPM_H_IDLE;
				default: h_state <= ULPM_H_IDLE;
			endcase
		end
	end

	// Outgoing token contents
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lpm_channel_index_out <= 4'h0;
			lpm_tx_dev_addr <= 7'h00;
			lpm_tx_ep_num <= 4'h0;
			lpm_tx_rwake <= 1'b0;
			lpm_tx_resume_duration_code <= 4'h0;
		end else begin
			lpm_channel_index_out <= chan_reg;
			lpm_tx_dev_addr <= chan_dev_addr; // [RULE7]
			lpm_tx_ep_num <= chan_ep_num; // [RULE7]
			lpm_tx_rwake <= rwake_reg; // [RULE18]
			lpm_tx_resume_duration_code <= resume_duration_code_reg; // [RULE19]
		end
	end

	// Device response to a received LPM token
	ulpm_resp_e dev_resp;
	always_comb begin
		if (!cap_reg)
			dev_resp = ULPM_RESP_NYET; // [RULE20]
		else if (dev_tok_error)
			dev_resp = ULPM_RESP_ERROR; // [RULE21] [RULE22]
		else if (dev_tok_link_state != 4'h1)
			dev_resp = ULPM_RESP_STALL; // [RULE21] [RULE22]
		else if (!swresp_reg || dev_tx_pending)
			dev_resp = ULPM_RESP_NYET; // [RULE21]
		else
			dev_resp = ULPM_RESP_ACK;
	end

	logic dev_tok;
	logic dev_ack_sent;
	assign dev_tok = dev_tok_valid && !host_mode;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dev_resp_valid <= 1'b0;
			dev_resp_code <= 2'h0;
			resp_reg <= 2'h0;
			rwake_reg <= 1'b0;
			resume_duration_code_reg <= 4'h0;
		end else begin
			dev_resp_valid <= dev_tok;
			if (dev_tok) begin
				dev_resp_code <= dev_resp;
				resp_reg <= dev_resp; // [RULE12]
				if (dev_resp != ULPM_RESP_ERROR) begin
					rwake_reg <= dev_tok_rwake; // [RULE18]
					resume_duration_code_reg <= dev_tok_resume_duration_code; // [RULE19]
				end
			end else if (host_mode && lpm_rx_valid && h_state == ULPM_H_WAIT) begin
				resp_reg <= lpm_rx_code; // [RULE12]
			end else if (wr_cfg) begin
				rwake_reg <= hwdata[`ULPM_B_RWAKE];
				resume_duration_code_reg <= hwdata[`ULPM_F_RESUME_DURATION_CODE_LSB +: 4];
			end
		end
	end

	// Sleep tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dev_ack_sent <= 1'b0;
		else if (host_mode || act_s2 || remote_wakeup_signal || port_reset || soft_disconnect)
			dev_ack_sent <= 1'b0;
		else if (dev_tok && dev_resp == ULPM_RESP_ACK)
			dev_ack_sent <= 1'b1;
		else if (dev_ack_sent && token_retry_timer)
			dev_ack_sent <= 1'b0;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_reg <= 1'b0;
		end else if (!host_mode) begin
			if (act_s2 || remote_wakeup_signal || port_reset || soft_disconnect)
				sleep_reg <= 1'b0; // [RULE9]
			else if (dev_ack_sent && token_retry_timer)
				sleep_reg <= 1'b1; // [RULE9]
		end else begin
			if (remote_l1_wakeup || port_reset || host_l1_resume || l1_wakeup_irq
				|| disconnect_irq)
				sleep_reg <= 1'b0; // [RULE11]
			else if (host_acked)
				sleep_reg <= 1'b1; // [RULE11]
		end
	end

	// L1 residency timer
	logic [$clog2(RES_CYC + 1)-1:0] res_cnt;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			res_cnt <= '0;
			resok_reg <= 1'b0;
		end else if (!sleep_reg) begin
			res_cnt <= '0;
			resok_reg <= 1'b0; // [RULE8]
		end else if (res_cnt == RES_CYC[$bits(res_cnt)-1:0] - 1'b1) begin
			resok_reg <= 1'b1; // [RULE8]
		end else begin
			res_cnt <= res_cnt + 1'b1;
		end
	end

	// Host-initiated resume drive, timed by the resume code
	logic [15:0] resume_cyc, resume_cnt;
	assign resume_cyc = 16'((`ULPM_RESUME_DURATION_CODE_BASE_US + `ULPM_RESUME_DURATION_CODE_STEP_US * int'(resume_duration_code_reg))
		* `ULPM_CLK_MHZ);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resume_cnt <= 16'h0000;
			host_resume_drive <= 1'b0;
		end else if (host_mode && host_l1_resume && sleep_reg && !host_resume_drive) begin
			resume_cnt <= resume_cyc; // [RULE19]
			host_resume_drive <= 1'b1;
		end else if (resume_cnt > 16'h0001) begin
			resume_cnt <= resume_cnt - 16'h0001;
		end else begin
			resume_cnt <= 16'h0000;
			host_resume_drive <= 1'b0;
		end
	end

	// PHY low-power signalling
	logic deep_ok;
	assign deep_ok = !host_mode && sleep_reg && thres_reg[4]
		&& (resume_duration_code_reg >= thres_reg[3:0]);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			deep_low_power_out <= 1'b0;
			phy_l1_suspend_n_out <= 1'b1;
			phy_sleep_n_out <= 1'b1;
			ulpi_func_ctrl_wr <= 1'b0;
			ulpi_func_ctrl_bit7 <= 1'b0;
		end else begin
			deep_low_power_out <= deep_ok; // [RULE13]
			phy_l1_suspend_n_out <= !deep_ok;
			phy_sleep_n_out <= !(!ULPI_PHY && sleep_reg && physlp_reg && !deep_ok); // [RULE16]
			ulpi_func_ctrl_wr <= ULPI_PHY && physlp_reg && sleep_reg
				&& !ulpi_func_ctrl_bit7; // [RULE15]
			if (ULPI_PHY && physlp_reg)
				ulpi_func_ctrl_bit7 <= sleep_reg && !deep_ok; // [RULE15]
		end
	end

	// Assertions
	sequence s_nack_reply;
		lpm_rx_valid && h_state == ULPM_H_WAIT && lpm_rx_code != ULPM_RESP_ERROR;
	endsequence
	property p_send_clear;
		@(posedge hclk) disable iff (!hresetn) s_nack_reply |=> !send_reg;
	endproperty
	a_send_clear: assert property (p_send_clear) else $error("send bit not cleared"); // [RULE4]
	property p_retry_dec;
		@(posedge hclk) disable iff (!hresetn)
		(h_state == ULPM_H_WAIT && lpm_rx_valid && lpm_rx_code == ULPM_RESP_ERROR
		&& retleft_reg != 3'h0) |=> (retleft_reg == $past(retleft_reg) - 3'h1);
	endproperty
	a_retry_dec: assert property (p_retry_dec) else $error("retry count wrong"); // [RULE6]
	property p_nocap_nyet;
		@(posedge hclk) disable iff (!hresetn)
		(dev_tok && !cap_reg) |=> dev_resp_code == ULPM_RESP_NYET;
	endproperty
	a_nocap_nyet: assert property (p_nocap_nyet) else $error("NYET expected"); // [RULE20]
	property p_err_resp;
		@(posedge hclk) disable iff (!hresetn)
		(dev_tok && cap_reg && dev_tok_error) |=> dev_resp_code == ULPM_RESP_ERROR;
	endproperty
	a_err_resp: assert property (p_err_resp) else $error("ERROR expected"); // [RULE21]
	property p_resok_clear;
		@(posedge hclk) disable iff (!hresetn) !sleep_reg |=> !resok_reg;
	endproperty
	a_resok_clear: assert property (p_resok_clear) else $error("resume ok stuck"); // [RULE8]
	property p_resok_late;
		@(posedge hclk) disable iff (!hresetn) $rose(sleep_reg) |-> !resok_reg[*8];
	endproperty
	a_resok_late: assert property (p_resok_late) else $error("resume ok early"); // [RULE8]
	property p_attach_ro;
		@(posedge hclk) disable iff (!hresetn) (wr_cfg && !attach_wr_ok) |=> $stable(attach_reg);
	endproperty
	a_attach_ro: assert property (p_attach_ro) else $error("attach bit written"); // [RULE2]
	property p_cap_zero;
		@(posedge hclk) disable iff (!hresetn) !LPM_BUILD_OPTION |-> !cap_reg;
	endproperty
	a_cap_zero: assert property (p_cap_zero) else $error("capable bit set"); // [RULE23]
	property p_deep;
		@(posedge hclk) disable iff (!hresetn) deep_low_power_out |-> $past(thres_reg[4]);
	endproperty
	a_deep: assert property (p_deep) else $error("deep sleep without enable"); // [RULE13]
	property p_host_sleep;
		@(posedge hclk) disable iff (!hresetn)
		(host_mode && disconnect_irq) |=> !sleep_reg;
	endproperty
	a_host_sleep: assert property (p_host_sleep) else $error("sleep not cleared"); // [RULE11]
endmodule : ulpm_control

// [testbench/ulpm_peer_model.sv]
// Peer model: answers LPM token pairs and serves the host channel table
module ulpm_peer_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic lpm_tx_start,
	input wire logic [3:0] lpm_channel_index_out,
	input wire logic [6:0] lpm_tx_dev_addr,
	input wire logic [3:0] lpm_tx_ep_num,
	input wire logic lpm_tx_rwake,
	input wire logic [3:0] lpm_tx_resume_duration_code,
	input wire logic [7:0] codes,
	input wire logic slow,
	output logic lpm_tx_ready,
	output logic lpm_rx_valid,
	output logic [1:0] lpm_rx_code,
	output logic [6:0] chan_dev_addr,
	output logic [3:0] chan_ep_num,
	output logic [7:0] starts,
	output logic [15:0] seen
);
	logic [3:0] wait_cnt;
	logic [1:0] idx;
	logic [1:0] nxt;
	assign nxt = codes[{idx, 1'b0} +: 2];
	// Each channel holds a distinct address and endpoint
	assign chan_dev_addr = {3'h4, lpm_channel_index_out};
	assign chan_ep_num = ~lpm_channel_index_out;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lpm_tx_ready <= 1'b1;
			lpm_rx_valid <= 1'b0;
			lpm_rx_code <= 2'h0;
			starts <= 8'h00;
			seen <= 16'h0000;
			wait_cnt <= 4'h0;
			idx <= 2'h0;
		end else if (lpm_tx_start) begin
			starts <= starts + 8'h01;
			seen <= {lpm_tx_dev_addr, lpm_tx_ep_num, lpm_tx_rwake, lpm_tx_resume_duration_code};
			wait_cnt <= slow ? 4'h6 : 4'h2;
			lpm_tx_ready <= 1'b0;
		end else if (wait_cnt == 4'h1) begin
			lpm_rx_valid <= 1'b1;
			lpm_rx_code <= nxt;
			idx <= (nxt == 2'h0) ? idx + 2'h1 : 2'h0;
			lpm_tx_ready <= 1'b1;
			wait_cnt <= 4'h0;
		end else begin
			// Code is meaningless outside the answer cycle
			if (wait_cnt != 4'h0) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
			lpm_rx_valid <= 1'b0;
			lpm_rx_code <= ~lpm_rx_code;
		end
	end
endmodule : ulpm_peer_model

// [testbench/ulpm_control_bench.sv]
// Self-checking bench for the LPM control block
`include "ulpm_regs.svh"
module ulpm_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import ulpm_pkg::*;
	localparam logic [11:0] CFG = `ULPM_CFG_OFFSET;
	localparam int RES_CYC = (`ULPM_RESUME_DURATION_CODE_BASE_US + 3 * `ULPM_RESUME_DURATION_CODE_STEP_US) * `ULPM_CLK_MHZ;
	localparam logic [9:0] CASES [8] = '{10'b1000001010, 10'b1110001000, 10'b1100010001,
		10'b1100001110, 10'b0100010001, 10'b0110001000, 10'b0100001010, 10'b1100001011};
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, host_mode, strobe_link_select;
	logic line_idle, bus_activity, dev_tok_valid, dev_tok_error, dev_tok_rwake;
	logic dev_tx_pending, token_retry_timer, slow, lpm_tx_ready, lpm_rx_valid, lpm_tx_start;
	logic lpm_tx_rwake, dev_resp_valid, host_drive_idle, dev_connect_start, host_resume_drive;
	logic deep_low_power_out, phy_l1_suspend_n_out, phy_sleep_n_out;
	logic ulpi_func_ctrl_wr, ulpi_func_ctrl_bit7;
	logic [11:0] haddr;
	logic [1:0] htrans, lpm_rx_code, dev_resp_code;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic [3:0] dev_tok_link_state, dev_tok_resume_duration_code, chan_ep_num, lpm_channel_index_out;
	logic [3:0] lpm_tx_ep_num, lpm_tx_resume_duration_code;
	logic [6:0] ev, chan_dev_addr, lpm_tx_dev_addr;
	logic [7:0] codes, starts, s0;
	logic [15:0] seen;
	wire hready;
	int err_total, samples_checked, k, n;
	assign hready = hreadyout;
	ulpm_control dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout, .hresp, .host_mode, .strobe_link_select, .line_idle,
		.bus_activity, .chan_dev_addr, .chan_ep_num, .lpm_tx_ready, .lpm_rx_valid,
		.lpm_rx_code, .dev_tok_valid, .dev_tok_error, .dev_tok_link_state, .dev_tok_rwake,
		.dev_tok_resume_duration_code, .dev_tx_pending, .token_retry_timer, .remote_wakeup_signal(ev[0]),
		.soft_disconnect(ev[1]), .port_reset(ev[2]), .remote_l1_wakeup(ev[3]),
		.host_l1_resume(ev[4]), .l1_wakeup_irq(ev[5]), .disconnect_irq(ev[6]),
		.lpm_channel_index_out, .lpm_tx_start, .lpm_tx_dev_addr, .lpm_tx_ep_num,
		.lpm_tx_rwake, .lpm_tx_resume_duration_code, .dev_resp_valid, .dev_resp_code, .host_drive_idle,
		.dev_connect_start, .host_resume_drive, .deep_low_power_out, .phy_l1_suspend_n_out,
		.phy_sleep_n_out, .ulpi_func_ctrl_wr, .ulpi_func_ctrl_bit7);
	ulpm_peer_model peer (.hclk, .hresetn, .lpm_tx_start, .lpm_channel_index_out,
		.lpm_tx_dev_addr, .lpm_tx_ep_num, .lpm_tx_rwake, .lpm_tx_resume_duration_code, .codes, .slow,
		.lpm_tx_ready, .lpm_rx_valid, .lpm_rx_code, .chan_dev_addr, .chan_ep_num, .starts,
		.seen);
	task automatic close_out();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	task automatic lost(input string m);
		$display("unexpected at %0t: %s timed out", $time, m);
		err_total++;
		close_out();
	endtask : lost
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
			err_total++;
		end
	endtask : chk
	task automatic tick(input int c);
		repeat (c) @(posedge hclk);
	endtask : tick
	task automatic wait_rdy();
		int w;
		w = 0;
		@(posedge hclk);
		while (hready !== 1'b1 && w < 50) begin
			@(posedge hclk);
			w++;
		end
		if (w >= 50) lost("bus");
	endtask : wait_rdy
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : bus
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		tick(1);
		ev <= 7'h00;
		tick(4);
	endtask : pulse
	task automatic host_lpm(input logic [2:0] lim, input logic [7:0] c, input logic [7:0] na,
		input logic [1:0] last);
		s0 = starts;
		codes <= c;
		// Capable bit and retry limit are taken from the stored word, so store them first
		bus(1'b1, CFG, {8'h00, lim, 21'h0a004d});
		bus(1'b1, CFG, {8'h01, lim, 21'h0a004d});
		k = 0;
		do begin
			bus(1'b0, CFG, 32'h0);
			k++;
		end while (rd[24] !== 1'b0 && k < 40);
		if (k >= 40) lost("send");
		tick(4);
		bus(1'b0, CFG, 32'h0);
		chk(starts - s0, na, "attempts");
		chk(seen, {7'h45, 4'ha, 1'b1, 4'h3}, "token fields");
		chk({rd[15], rd[14:13]}, {last == 2'h3, last}, "host result");
	endtask : host_lpm
	task automatic dev_tok(input logic [9:0] t);
		bus(1'b1, CFG, {30'h00000620, t[9:8]});
		dev_tok_error <= t[7];
		dev_tok_link_state <= t[6:3];
		dev_tx_pending <= t[2];
		dev_tok_valid <= 1'b1;
		tick(1);
		dev_tok_valid <= 1'b0;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (dev_resp_valid !== 1'b1 && k < 10);
		if (k >= 10) lost("response");
		chk(dev_resp_code, t[1:0], "device answer");
	endtask : dev_tok
	task automatic dev_sleep();
		dev_tok(CASES[7]);
		token_retry_timer <= 1'b1;
		tick(1);
		token_retry_timer <= 1'b0;
		tick(6);
		bus(1'b0, CFG, 32'h0);
		chk({rd[15:13], rd[6], rd[5:2]}, 8'hf9, "device sleep");
		chk({deep_low_power_out, phy_l1_suspend_n_out, phy_sleep_n_out, hresp}, 4'ha,
			"deep sleep");
	endtask : dev_sleep
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	initial begin
		#8000000;
		lost("run");
	end
	initial begin
		{hresetn, hsel, hwrite, line_idle, bus_activity, dev_tok_valid, slow} = 7'h00;
		{dev_tok_error, dev_tx_pending, token_retry_timer, strobe_link_select} = 4'h0;
		{haddr, htrans, hwdata, ev, codes, dev_tok_link_state} = 0;
		hsize = 3'h2;
		host_mode = 1'b1;
		dev_tok_rwake = 1'b1;
		dev_tok_resume_duration_code = 4'h9;
		err_total = 0;
		samples_checked = 0;
		tick(20);
		hresetn <= 1'b1;
		bus(1'b0, CFG, 32'h0);
		chk(rd, `ULPM_CFG_RESET, "reset value");
		bus(1'b0, `ULPM_STAT_OFFSET, 32'h0);
		chk(rd, 32'h1, "status idle");
		bus(1'b1, 12'h100, 32'hffffffff);
		bus(1'b0, 12'h100, 32'h0);
		chk(rd, 32'h0, "unmapped");
		bus(1'b1, CFG, 32'h3e01e000);
		bus(1'b0, CFG, 32'h0);
		chk(rd, 32'h0, "read-only bits");
		bus(1'b1, CFG, 32'h40000000);
		bus(1'b0, CFG, 32'h0);
		chk(rd[30], 1'b0, "attach unselected");
		strobe_link_select <= 1'b1;
		bus(1'b1, CFG, 32'h80000000);
		bus(1'b1, CFG, 32'hc0000000);
		bus(1'b0, CFG, 32'h0);
		chk(rd[31:30], 2'h2, "attach inverted");
		bus(1'b1, CFG, 32'h0);
		bus(1'b1, CFG, 32'h40000000);
		tick(4);
		chk(host_drive_idle, 1'b1, "host idle drive");
		bus(1'b1, CFG, 32'h0);
		host_mode <= 1'b0;
		line_idle <= 1'b1;
		bus(1'b1, CFG, 32'h40000000);
		k = 0;
		while (dev_connect_start !== 1'b1 && k < 40) begin
			tick(1);
			k++;
		end
		chk(k < 40, 1'b1, "device connect");
		bus(1'b1, CFG, 32'h1);
		host_mode <= 1'b1;
		line_idle <= 1'b0;
		bus(1'b0, CFG, 32'h0);
		chk(rd[30:0], 31'h1, "capable bit");
		bus(1'b1, CFG, 32'h0);
		s0 = starts;
		bus(1'b1, CFG, 32'h01000000);
		tick(10);
		bus(1'b0, CFG, 32'h0);
		chk({starts, rd[24]}, {s0, 1'b0}, "send refused");
		host_lpm(3'h1, 8'h02, 8'h01, 2'h2);
		slow <= 1'b1;
		host_lpm(3'h1, 8'h01, 8'h01, 2'h1);
		slow <= 1'b0;
		host_lpm(3'h2, 8'h30, 8'h03, 2'h3);
		tick(`ULPM_RESIDENCY_CYC + 10);
		bus(1'b0, CFG, 32'h0);
		chk(rd[16:15], 2'h3, "resume permitted");
		for (int i = 2; i < 7; i++) begin
			if (i != 2) host_lpm(3'h0, 8'h03, 8'h01, 2'h3);
			pulse(i);
			if (i == 4) begin
				n = 0;
				while (host_resume_drive === 1'b1 && n < 4000) begin
					tick(1);
					n++;
				end
				chk(n + 5 >= RES_CYC && n <= RES_CYC + 3, 1'b1, "resume time");
			end
			bus(1'b0, CFG, 32'h0);
			chk(rd[16:15], 2'h0, "host wake");
		end
		host_lpm(3'h1, 8'h00, 8'h02, 2'h0);
		host_mode <= 1'b0;
		for (int i = 0; i < 7; i++) dev_tok(CASES[i]);
		for (int j = 0; j < 4; j++) begin
			dev_sleep();
			if (j == 3) begin
				bus_activity <= 1'b1;
				tick(2);
				bus_activity <= 1'b0;
				tick(4);
			end else begin
				pulse(j);
			end
			bus(1'b0, CFG, 32'h0);
			chk(rd[15], 1'b0, "device wake");
		end
		// Sleep with the deep threshold disabled hands the sleep request to the PHY
		dev_tok(CASES[7]);
		bus(1'b1, CFG, 32'h00000883);
		token_retry_timer <= 1'b1;
		tick(1);
		token_retry_timer <= 1'b0;
		tick(4);
		chk({deep_low_power_out, phy_l1_suspend_n_out, phy_sleep_n_out}, 3'h2,
			"phy sleep");
		close_out();
	end
endmodule : ulpm_control_bench
